// *** audio_pm_pkg.sv ***
package audio_pm_pkg;

	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int SEL_W = 4;
	localparam int FB_W = 9;
	localparam int OD_W = 2;
	localparam int IN_W = 5;
	localparam int NF_W = 10;
	localparam int NR_W = 6;
	localparam int NO_W = 3;
	localparam int DIV_W = 8;
	localparam int WAKE_N = 2;
	localparam int IRQ_N = 4;

	localparam logic [ADDR_W-1:0] ADDR_AUDIO_PLL = 32'hfff0_0010;
	localparam logic [ADDR_W-1:0] ADDR_AUDIO_ROUTE = 32'hfff0_0014;
	localparam logic [ADDR_W-1:0] ADDR_WAKE_CTRL = 32'hfff0_0020;
	localparam logic [ADDR_W-1:0] ADDR_WAKE_FLAGS = 32'hfff0_0024;
	localparam logic [ADDR_W-1:0] ADDR_POWER_MODE = 32'hfff0_0028;
	localparam logic [ADDR_W-1:0] ADDR_XCVR_PATH = 32'hfff0_0030;

	localparam logic [DATA_W-1:0] AUDIO_PLL_RESET = 32'h0001_0000;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

	// Crystal reference shared with the system PLL, and the audio targets
	localparam int REF_CLOCK_HZ = 15_000_000;
	localparam int AUDIO_TARGET_A_HZ = 12_288_000;
	localparam int AUDIO_TARGET_B_HZ = 16_934_000;

	localparam logic [NF_W-1:0] FB_OFFSET = 10'h002;
	localparam logic [NR_W-1:0] IN_OFFSET = 6'h02;
	localparam logic [NO_W-1:0] NO_ONE = 3'h1;
	localparam logic [NO_W-1:0] NO_TWO = 3'h2;
	localparam logic [NO_W-1:0] NO_FOUR = 3'h4;
	localparam logic [OD_W-1:0] OD_BY1 = 2'h0;
	localparam logic [OD_W-1:0] OD_BY4 = 2'h3;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

	typedef struct packed {
		logic [14:0] reserved;
		logic audio_pll_power_off;
		logic [FB_W-1:0] audio_pll_feedback_div;
		logic [OD_W-1:0] audio_pll_output_div;
		logic [IN_W-1:0] audio_pll_input_div;
	} audio_pll_control_s;

	typedef struct packed {
		logic [22:0] reserved;
		logic audio_clock_route_enable;
		logic [DIV_W-1:0] audio_clock_divisor;
	} audio_clock_route_s;

	typedef struct packed {
		logic [25:0] reserved_hi;
		logic [WAKE_N-1:0] wake_level_select;
		logic [1:0] reserved_lo;
		logic [WAKE_N-1:0] wake_source_enable;
	} wake_control_s;

	typedef struct packed {
		logic [28:0] reserved;
		logic memory_clock_halt;
		logic deep_sleep_enable;
		logic idle_enable;
	} power_mode_control_s;

	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_IDLE = 2'b01,
		PM_SLEEP = 2'b11
	} pm_state_e;

	function automatic logic [NF_W-1:0] feedback_divisor(input logic [FB_W-1:0] fb);
		feedback_divisor = {1'b0, fb} + FB_OFFSET;
	endfunction : feedback_divisor

	function automatic logic [NR_W-1:0] input_divisor(input logic [IN_W-1:0] in_div);
		input_divisor = {1'b0, in_div} + IN_OFFSET;
	endfunction : input_divisor

	function automatic logic [NO_W-1:0] output_divisor(input logic [OD_W-1:0] od);
		case (od)
			OD_BY1: output_divisor = NO_ONE;
			OD_BY4: output_divisor = NO_FOUR;
			default: output_divisor = NO_TWO;
		endcase
	endfunction : output_divisor

	function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
			input logic [DATA_W-1:0] new_v, input logic [SEL_W-1:0] sel);
		merge_bytes = old_v;
		for (int i = 0; i < SEL_W; i++) begin
			if (sel[i]) begin
				merge_bytes[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
	endfunction : merge_bytes

endpackage : audio_pm_pkg

// *** audio_power_manager.sv ***
// Operation
// - Audio PLL power-off bit 16 holds PLL down when set, reset default set
// - Feedback field bits 15:7 divides oscillator output by value plus two
// - Input field bits 4:0 divides the reference by value plus two
// - Output field bits 6:5 divides by 1, 2, 2 or 4
// - Output frequency is reference times feedback over input and output divisors
// - Route enable bit 8 passes PLL output to audio clock, else blocks it
// - Divisor bits 7:0 give audio clock as PLL output over value plus one
// - Level bits 5 and 4 pick high or low wake level for inputs 1, 0
// - Enable bits 1 and 0 permit wakeup by inputs 1 and 0
// - Flag bits 1 and 0 read one when that input woke the chip
// - Idle bit 0 stops core clock; enabled peripherals keep running
// - Any normal or fast interrupt request releases the core from idle
// - Memory halt bit 2 with idle stops memory controller clock
// - Power-down bit 1 stops oscillator and both PLLs
// - Inputs 3 to 0, keypad or reset pin end power-down
// - Transceiver bit 0 selects host when set, device when clear
// - Audio PLL uses the 15 MHz crystal and targets audio rates
//
// Added by the designer: the Wishbone slave port.
module audio_power_manager import audio_pm_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DATA_W-1:0] wb_dat_i,
	output logic [DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [IRQ_N-1:0] external_interrupt_n_i,
	input wire logic fast_interrupt_n_i,
	input wire logic keypad_wake_i,
	input wire logic reset_pin_wake_i,
	input wire logic audio_pll_tick_i,
	output logic audio_pll_power_off_o,
	output logic [FB_W-1:0] audio_pll_feedback_div_o,
	output logic [OD_W-1:0] audio_pll_output_div_o,
	output logic [IN_W-1:0] audio_pll_input_div_o,
	output logic [NF_W-1:0] audio_pll_nf_o,
	output logic [NR_W-1:0] audio_pll_nr_o,
	output logic [NO_W-1:0] audio_pll_no_o,
	output logic audio_clock_tick_o,
	output logic core_clock_enable_o,
	output logic memory_clock_enable_o,
	output logic oscillator_stop_o,
	output logic system_pll_stop_o,
	output logic core_idle_o,
	output logic power_down_o,
	output logic transceiver_host_select_o
);

	typedef struct packed {
		audio_pll_control_s pll;
		audio_clock_route_s route;
		wake_control_s wake;
		logic [WAKE_N-1:0] flags;
		power_mode_control_s pmode;
		logic host_select;
		pm_state_e mode;
		logic ack;
		logic [DATA_W-1:0] rdata;
		logic [NF_W-1:0] nf;
		logic [NR_W-1:0] nr;
		logic [NO_W-1:0] no;
	} manager_state_s;

	manager_state_s state;
	manager_state_s next_state;
	wake_link_if link ();
	logic request;
	logic write_now;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] flag_word;
	logic [DATA_W-1:0] host_word;
	logic interrupt_request;
	logic audio_enable;

	wake_detect wake_unit (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.external_interrupt_n_i(external_interrupt_n_i),
		.keypad_wake_i(keypad_wake_i),
		.reset_pin_wake_i(reset_pin_wake_i),
		.link(link)
	);

	assign link.enable = state.wake.wake_source_enable;
	assign link.level_high = state.wake.wake_level_select;
	assign link.sleeping = (state.mode == PM_SLEEP);

	// No audio clock while the path is blocked or its PLL has no power
	assign audio_enable = state.route.audio_clock_route_enable & ~audio_pll_power_off_o;

	audio_prescaler prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(audio_enable),
		.divisor_i(state.route.audio_clock_divisor),
		.pll_tick_i(audio_pll_tick_i),
		.audio_tick_o(audio_clock_tick_o)
	);

	assign request = wb_cyc_i & wb_stb_i;
	// One write per transfer: taken in the cycle that raises ack
	assign write_now = request & wb_we_i & ~state.ack;
	assign interrupt_request = ~&external_interrupt_n_i | ~fast_interrupt_n_i;
	assign flag_word = {{(DATA_W-WAKE_N){1'b0}}, state.flags};
	assign host_word = {{(DATA_W-1){1'b0}}, state.host_select};

	always_comb begin
		wdata = ZERO_WORD;
		next_state = state;
		next_state.ack = request & ~state.ack;

		// Register reads; unmapped addresses answer with zero
		if (request & ~state.ack) begin
			case (wb_adr_i)
				ADDR_AUDIO_PLL: next_state.rdata = state.pll;
				ADDR_AUDIO_ROUTE: next_state.rdata = state.route;
				ADDR_WAKE_CTRL: next_state.rdata = state.wake;
				ADDR_WAKE_FLAGS: next_state.rdata = flag_word;
				ADDR_POWER_MODE: next_state.rdata = state.pmode;
				ADDR_XCVR_PATH: next_state.rdata = host_word;
				default: next_state.rdata = ZERO_WORD;
			endcase
		end

		// Register writes with byte lanes; reserved bits stay zero
		if (write_now) begin
			case (wb_adr_i)
				ADDR_AUDIO_PLL: begin
					next_state.pll = merge_bytes(state.pll, wb_dat_i, wb_sel_i);
					next_state.pll.reserved = '0;
				end
				ADDR_AUDIO_ROUTE: begin
					next_state.route = merge_bytes(state.route, wb_dat_i, wb_sel_i);
					next_state.route.reserved = '0;
				end
				ADDR_WAKE_CTRL: begin
					next_state.wake = merge_bytes(state.wake, wb_dat_i, wb_sel_i);
					next_state.wake.reserved_hi = '0;
					next_state.wake.reserved_lo = '0;
				end
				ADDR_WAKE_FLAGS: begin
					wdata = merge_bytes(flag_word, wb_dat_i, wb_sel_i);
					next_state.flags = state.flags & wdata[WAKE_N-1:0];
				end
				ADDR_POWER_MODE: begin
					next_state.pmode = merge_bytes(state.pmode, wb_dat_i, wb_sel_i);
					next_state.pmode.reserved = '0;
				end
				ADDR_XCVR_PATH: begin
					wdata = merge_bytes(host_word, wb_dat_i, wb_sel_i);
					next_state.host_select = wdata[0];
				end
				default: begin
					next_state.rdata = next_state.rdata;
				end
			endcase
		end

		// Power mode sequencing; deep sleep outranks idle
		case (state.mode)
			PM_RUN: begin
				if (next_state.pmode.deep_sleep_enable) begin
					next_state.mode = PM_SLEEP;
				end else if (next_state.pmode.idle_enable) begin
					next_state.mode = PM_IDLE;
				end
			end
			PM_IDLE: begin
				if (next_state.pmode.deep_sleep_enable) begin
					next_state.mode = PM_SLEEP;
				end else if (interrupt_request | ~next_state.pmode.idle_enable) begin
					// Interrupt ends idle and drops the request bit
					next_state.mode = PM_RUN;
					next_state.pmode.idle_enable = 1'b0;
				end
			end
			PM_SLEEP: begin
				if (link.wake) begin
					next_state.mode = PM_RUN;
					next_state.pmode.deep_sleep_enable = 1'b0;
					next_state.pmode.idle_enable = 1'b0;
				end else if (~next_state.pmode.deep_sleep_enable) begin
					next_state.mode = PM_RUN;
				end
			end
			default: begin
				next_state.mode = PM_RUN;
			end
		endcase

		// Hardware set wins over a software clear in the same cycle
		if (state.mode == PM_SLEEP && link.wake) begin
			next_state.flags = next_state.flags | link.hits;
		end

		// Divisors held in flops so the analog side sees stable values
		next_state.nf = feedback_divisor(next_state.pll.audio_pll_feedback_div);
		next_state.nr = input_divisor(next_state.pll.audio_pll_input_div);
		next_state.no = output_divisor(next_state.pll.audio_pll_output_div);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
			state.pll <= AUDIO_PLL_RESET;
			state.nf <= FB_OFFSET;
			state.nr <= IN_OFFSET;
			state.no <= NO_ONE;
			state.mode <= PM_RUN;
		end else begin
			state <= next_state;
		end
	end

	assign wb_ack_o = state.ack;
	assign wb_dat_o = state.rdata;

	// Fout = 15 MHz reference * nf / nr / no
	assign audio_pll_feedback_div_o = state.pll.audio_pll_feedback_div;
	assign audio_pll_output_div_o = state.pll.audio_pll_output_div;
	assign audio_pll_input_div_o = state.pll.audio_pll_input_div;
	assign audio_pll_nf_o = state.nf;
	assign audio_pll_nr_o = state.nr;
	assign audio_pll_no_o = state.no;

	assign power_down_o = (state.mode == PM_SLEEP);
	assign core_idle_o = (state.mode == PM_IDLE);
	assign audio_pll_power_off_o = state.pll.audio_pll_power_off | power_down_o;
	assign oscillator_stop_o = power_down_o;
	assign system_pll_stop_o = power_down_o;
	// Peripheral gating lives in the clock-gate register outside this block
	assign core_clock_enable_o = ~(core_idle_o | power_down_o);
	// Memory halt needs self-refresh first; nothing here checks it
	assign memory_clock_enable_o = ~((core_idle_o & state.pmode.memory_clock_halt) | power_down_o);
	assign transceiver_host_select_o = state.host_select;

endmodule : audio_power_manager

// *** audio_power_manager_sva.sv ***
module audio_power_manager_sva import audio_pm_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [IRQ_N-1:0] external_interrupt_n_i,
	input wire logic fast_interrupt_n_i,
	input wire logic keypad_wake_i,
	input wire logic audio_pll_tick_i,
	input wire logic audio_pll_power_off_o,
	input wire logic [FB_W-1:0] audio_pll_feedback_div_o,
	input wire logic [OD_W-1:0] audio_pll_output_div_o,
	input wire logic [IN_W-1:0] audio_pll_input_div_o,
	input wire logic [NF_W-1:0] audio_pll_nf_o,
	input wire logic [NR_W-1:0] audio_pll_nr_o,
	input wire logic [NO_W-1:0] audio_pll_no_o,
	input wire logic audio_clock_tick_o,
	input wire logic core_clock_enable_o,
	input wire logic memory_clock_enable_o,
	input wire logic oscillator_stop_o,
	input wire logic system_pll_stop_o,
	input wire logic core_idle_o,
	input wire logic power_down_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_irq;
		core_idle_o && (!fast_interrupt_n_i || external_interrupt_n_i != 4'hf);
	endsequence
	sequence s_wake;
		power_down_o && (keypad_wake_i || external_interrupt_n_i[3:2] != 2'h3);
	endsequence
	a_ack_follows_req: assert property (s_req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_nf_offset: assert property (audio_pll_nf_o == {1'h0, audio_pll_feedback_div_o} + 10'h002)
		else $error("feedback divisor wrong");
	a_nr_offset: assert property (audio_pll_nr_o == {1'h0, audio_pll_input_div_o} + 6'h02)
		else $error("input divisor wrong");
	a_no_table: assert property (audio_pll_no_o == (audio_pll_output_div_o == 2'h0 ? 3'h1 :
		audio_pll_output_div_o == 2'h3 ? 3'h4 : 3'h2))
		else $error("output divisor wrong");
	a_sleep_stops: assert property (power_down_o |-> oscillator_stop_o &&
		system_pll_stop_o && audio_pll_power_off_o)
		else $error("clocks run in power-down");
	a_idle_gates: assert property (core_idle_o |-> !core_clock_enable_o)
		else $error("core clock runs in idle");
	a_mem_halt: assert property (!memory_clock_enable_o |-> core_idle_o || power_down_o)
		else $error("memory clock halted outside idle");
	a_idle_exit: assert property (s_irq |-> ##[1:3] !core_idle_o)
		else $error("interrupt did not end idle");
	a_wake_exit: assert property (s_wake |-> ##[1:3] !power_down_o)
		else $error("wake source did not end power-down");
	a_tick_cause: assert property (audio_clock_tick_o |->
		$past(audio_pll_tick_i) && !$past(audio_pll_power_off_o))
		else $error("audio tick without powered PLL tick");
endmodule : audio_power_manager_sva

bind audio_power_manager audio_power_manager_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.external_interrupt_n_i(external_interrupt_n_i), .fast_interrupt_n_i(fast_interrupt_n_i),
	.keypad_wake_i(keypad_wake_i), .audio_pll_tick_i(audio_pll_tick_i),
	.audio_pll_power_off_o(audio_pll_power_off_o),
	.audio_pll_feedback_div_o(audio_pll_feedback_div_o),
	.audio_pll_output_div_o(audio_pll_output_div_o),
	.audio_pll_input_div_o(audio_pll_input_div_o), .audio_pll_nf_o(audio_pll_nf_o),
	.audio_pll_nr_o(audio_pll_nr_o), .audio_pll_no_o(audio_pll_no_o),
	.audio_clock_tick_o(audio_clock_tick_o), .core_clock_enable_o(core_clock_enable_o),
	.memory_clock_enable_o(memory_clock_enable_o), .oscillator_stop_o(oscillator_stop_o),
	.system_pll_stop_o(system_pll_stop_o), .core_idle_o(core_idle_o),
	.power_down_o(power_down_o));

// *** audio_power_manager_tb.sv ***
module audio_power_manager_tb import audio_pm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
	int failures = 0;
	int num_checks = 0;
	int ticks = 0;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc_i = 1'h0;
	logic wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0;
	logic [ADDR_W-1:0] wb_adr_i = '0;
	logic [SEL_W-1:0] wb_sel_i = '0;
	logic [DATA_W-1:0] wb_dat_i = '0;
	logic [DATA_W-1:0] wb_dat_o;
	logic [DATA_W-1:0] rd;
	logic wb_ack_o;
	logic [IRQ_N-1:0] external_interrupt_n_i = 4'hf;
	logic fast_interrupt_n_i = 1'h1;
	logic keypad_wake_i = 1'h0;
	logic reset_pin_wake_i = 1'h0;
	logic audio_pll_tick_i = 1'h0;
	logic audio_pll_power_off_o;
	logic [FB_W-1:0] audio_pll_feedback_div_o;
	logic [OD_W-1:0] audio_pll_output_div_o;
	logic [IN_W-1:0] audio_pll_input_div_o;
	logic [NF_W-1:0] audio_pll_nf_o;
	logic [NR_W-1:0] audio_pll_nr_o;
	logic [NO_W-1:0] audio_pll_no_o;
	logic audio_clock_tick_o;
	logic core_clock_enable_o;
	logic memory_clock_enable_o;
	logic oscillator_stop_o;
	logic system_pll_stop_o;
	logic core_idle_o;
	logic power_down_o;
	logic transceiver_host_select_o;
	logic [ADDR_W-1:0] regs [6] = '{ADDR_AUDIO_PLL, ADDR_AUDIO_ROUTE, ADDR_WAKE_CTRL,
		ADDR_WAKE_FLAGS, ADDR_POWER_MODE, ADDR_XCVR_PATH};
	logic [NO_W-1:0] nos [4] = '{3'h1, 3'h2, 3'h2, 3'h4};
	int divs [4] = '{0, 1, 3, 5};

	audio_power_manager u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .external_interrupt_n_i,
		.fast_interrupt_n_i, .keypad_wake_i, .reset_pin_wake_i, .audio_pll_tick_i,
		.audio_pll_power_off_o, .audio_pll_feedback_div_o, .audio_pll_output_div_o,
		.audio_pll_input_div_o, .audio_pll_nf_o, .audio_pll_nr_o, .audio_pll_no_o,
		.audio_clock_tick_o, .core_clock_enable_o, .memory_clock_enable_o,
		.oscillator_stop_o, .system_pll_stop_o, .core_idle_o, .power_down_o,
		.transceiver_host_select_o);

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (audio_clock_tick_o === 1'h1) ticks++;
	end

	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	// Request held until ack is seen at an edge; one idle cycle after
	task automatic bus(input logic we, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d, input logic [SEL_W-1:0] s = 4'hf);
		int n = 0;
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 40);
		if (n >= 40) begin
			failures++;
			results();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge clk_i);
	endtask : bus

	task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		bus(1'h0, a, ZERO_WORD);
		`CHK(rd, e)
	endtask : chk_rd

	task automatic pulse(input int n);
		for (int i = 0; i < n; i++) begin
			audio_pll_tick_i <= 1'h1;
			@(posedge clk_i);
			audio_pll_tick_i <= 1'h0;
			@(posedge clk_i);
		end
		repeat (3) @(posedge clk_i);
	endtask : pulse

	// Bounded wait for power-down (0) or idle (1) to end
	task automatic wait_off(input int which);
		int n = 0;
		while ((which ? core_idle_o : power_down_o) !== 1'h0 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 20) begin
			failures++;
			results();
		end
	endtask : wait_off

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		for (int i = 0; i < 6; i++) chk_rd(regs[i], i == 0 ? AUDIO_PLL_RESET : ZERO_WORD);
		`CHK({audio_pll_power_off_o, audio_pll_nf_o, audio_pll_nr_o}, 17'h10082)
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, ADDR_AUDIO_PLL, {16'h0, i[0] ? 9'h1ff : 9'h000, i[1:0], i[0] ? 5'h00 : 5'h1f});
			`CHK(audio_pll_nf_o, i[0] ? 10'h201 : 10'h002)
			`CHK(audio_pll_nr_o, i[0] ? 6'h02 : 6'h21)
			`CHK(audio_pll_no_o, nos[i])
			`CHK(audio_pll_power_off_o, 1'h0)
			`CHK(audio_pll_feedback_div_o, i[0] ? 9'h1ff : 9'h000)
			`CHK({audio_pll_output_div_o, audio_pll_input_div_o}, {i[1:0], i[0] ? 5'h00 : 5'h1f})
		end
		$display("pll divider done");
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, ADDR_AUDIO_ROUTE, 32'h100 | divs[i]);
			ticks = 0;
			pulse(12);
			`CHK(ticks, 12 / (divs[i] + 1))
		end
		// Lane 1 only: clears the route enable, keeps the divisor
		bus(1'h1, ADDR_AUDIO_ROUTE, ZERO_WORD, 4'h2);
		chk_rd(ADDR_AUDIO_ROUTE, 32'h5);
		ticks = 0;
		pulse(12);
		`CHK(ticks, 0)
		bus(1'h1, ADDR_AUDIO_PLL, AUDIO_PLL_RESET);
		bus(1'h1, ADDR_AUDIO_ROUTE, 32'h100);
		pulse(4);
		`CHK({audio_pll_power_off_o, ticks}, {1'h1, 32'h0})
		$display("audio clock done");
		bus(1'h1, ADDR_WAKE_CTRL, 32'h21);
		bus(1'h1, ADDR_POWER_MODE, 32'h2);
		repeat (4) @(posedge clk_i);
		`CHK({power_down_o, oscillator_stop_o, system_pll_stop_o}, 3'h7)
		external_interrupt_n_i <= 4'he;
		wait_off(0);
		external_interrupt_n_i <= 4'hf;
		chk_rd(ADDR_WAKE_FLAGS, 32'h1);
		chk_rd(ADDR_POWER_MODE, ZERO_WORD);
		// One in bit 0 keeps the flag; zero in bit 1 clears nothing set
		bus(1'h1, ADDR_WAKE_FLAGS, 32'h1);
		chk_rd(ADDR_WAKE_FLAGS, 32'h1);
		bus(1'h1, ADDR_WAKE_FLAGS, ZERO_WORD);
		chk_rd(ADDR_WAKE_FLAGS, ZERO_WORD);
		// Input 1 idles high, so high-level select wakes at once
		bus(1'h1, ADDR_WAKE_CTRL, 32'h22);
		bus(1'h1, ADDR_POWER_MODE, 32'h2);
		wait_off(0);
		chk_rd(ADDR_WAKE_FLAGS, 32'h2);
		bus(1'h1, ADDR_WAKE_FLAGS, ZERO_WORD);
		bus(1'h1, ADDR_WAKE_CTRL, 32'h03);
		// Keypad, reset pin, then input 2: each wakes but sets no flag
		for (int k = 0; k < 3; k++) begin
			bus(1'h1, ADDR_POWER_MODE, 32'h2);
			repeat (4) @(posedge clk_i);
			`CHK(power_down_o, 1'h1)
			if (k == 0) begin
				keypad_wake_i <= 1'h1;
			end else if (k == 1) begin
				reset_pin_wake_i <= 1'h1;
			end else begin
				external_interrupt_n_i <= 4'hb;
			end
			wait_off(0);
			keypad_wake_i <= 1'h0;
			reset_pin_wake_i <= 1'h0;
			external_interrupt_n_i <= 4'hf;
			`CHK(power_down_o, 1'h0)
			chk_rd(ADDR_WAKE_FLAGS, ZERO_WORD);
		end
		$display("wake done");
		bus(1'h1, ADDR_POWER_MODE, 32'h5);
		`CHK({core_idle_o, core_clock_enable_o, memory_clock_enable_o}, 3'h4)
		fast_interrupt_n_i <= 1'h0;
		wait_off(1);
		fast_interrupt_n_i <= 1'h1;
		// Idle exit drops only the idle bit; memory halt stays set
		chk_rd(ADDR_POWER_MODE, 32'h4);
		bus(1'h1, ADDR_POWER_MODE, 32'h1);
		`CHK({core_idle_o, core_clock_enable_o, memory_clock_enable_o}, 3'h5)
		external_interrupt_n_i <= 4'hb;
		wait_off(1);
		external_interrupt_n_i <= 4'hf;
		`CHK(core_clock_enable_o, 1'h1)
		$display("idle done");
		bus(1'h1, ADDR_XCVR_PATH, 32'hffff_ffff);
		`CHK(transceiver_host_select_o, 1'h1)
		chk_rd(ADDR_XCVR_PATH, 32'h1);
		bus(1'h1, ADDR_XCVR_PATH, ZERO_WORD);
		`CHK(transceiver_host_select_o, 1'h0)
		bus(1'h1, 32'hfff0_0018, 32'hffff_ffff);
		chk_rd(32'hfff0_0018, ZERO_WORD);
		$display("transceiver done");
		results();
	end
endmodule : audio_power_manager_tb

// *** audio_prescaler.sv ***
module audio_prescaler import audio_pm_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic [DIV_W-1:0] divisor_i,
	input wire logic pll_tick_i,
	output logic audio_tick_o
);

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic tick;
	} audio_clock_divisor_state_s;

	audio_clock_divisor_state_s state;
	audio_clock_divisor_state_s next_state;

	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (!enable_i) begin
			// Blocked path restarts the count so the first tick is full length
			next_state.count = '0;
		end else if (pll_tick_i) begin
			if (state.count >= divisor_i) begin
				next_state.count = '0;
				next_state.tick = 1'b1;
			end else begin
				next_state.count = state.count + DIV_ONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign audio_tick_o = state.tick;

endmodule : audio_prescaler

// *** wake_detect.sv ***
module wake_detect import audio_pm_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [IRQ_N-1:0] external_interrupt_n_i,
	input wire logic keypad_wake_i,
	input wire logic reset_pin_wake_i,
	wake_link_if.detect link
);

	typedef struct packed {
		logic wake;
		logic [WAKE_N-1:0] hits;
	} wake_state_s;

	wake_state_s state;
	wake_state_s next_state;
	logic [WAKE_N-1:0] level_match;
	logic other_wake;

	always_comb begin
		// Selected level per input: high when the select bit is one
		level_match = ~(external_interrupt_n_i[WAKE_N-1:0] ^ link.level_high);
		// Upper inputs wake on their active low level only
		other_wake = ~&external_interrupt_n_i[IRQ_N-1:WAKE_N] | keypad_wake_i | reset_pin_wake_i;
		next_state.hits = link.sleeping ? (level_match & link.enable) : '0;
		next_state.wake = link.sleeping & ((|next_state.hits) | other_wake);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign link.wake = state.wake;
	assign link.hits = state.hits;

endmodule : wake_detect

// *** wake_link_if.sv ***
interface wake_link_if;
	import audio_pm_pkg::*;
	logic [WAKE_N-1:0] enable;
	logic [WAKE_N-1:0] level_high;
	logic sleeping;
	logic wake;
	logic [WAKE_N-1:0] hits;

	modport control (output enable, output level_high, output sleeping, input wake, input hits);
	modport detect (input enable, input level_high, input sleeping, output wake, output hits);
endinterface : wake_link_if
